// *** rtl/slx_consts.vh ***
// Constants for the sixteen-bit load execution block.
// Assumes inclusion by bare name from every rtl file that needs them.
`ifndef SLX_CONSTS_VH
`define SLX_CONSTS_VH

// Prefix and opcode bytes
`define SLX_PFX_XIDX 8'hDD
`define SLX_PFX_YIDX 8'hFD
`define SLX_PFX_EXT 8'hED
`define SLX_OP_IDX_IMM 8'h21
`define SLX_OP_LOAD_THIRD 8'h2A
`define SLX_OP_STORE_THIRD 8'h22

// Immediate pair-load pattern 00dd0001
`define SLX_IMM_TOP 2'h0
`define SLX_IMM_LOW 4'h1
// Extended pair forms 01dd1011 and 01dd0011
`define SLX_EXT_TOP 2'h1
`define SLX_EXT_LOAD_LOW 4'hB
`define SLX_EXT_STORE_LOW 4'h3

// Register file slots
`define SLX_SLOT_FIRST 3'h0
`define SLX_SLOT_SECOND 3'h1
`define SLX_SLOT_THIRD 3'h2
`define SLX_SLOT_STACK 3'h3
`define SLX_SLOT_XIDX 3'h4
`define SLX_SLOT_YIDX 3'h5

// Clock states per machine cycle
`define SLX_TS_FETCH 3'h4
`define SLX_TS_MEM 3'h3

// Reset values
`define SLX_RST_WORD 16'h0000
`define SLX_RST_BYTE 8'h00

`endif

// *** rtl/slx_load_exec.v ***
// Decode and execution control for the sixteen-bit load instruction group.
// Assumes a zero-wait memory on the same clock: read data valid at the last
// clock state of every bus cycle, writes taken at the end of the cycle.
`timescale 1ns/100ps
`include "slx_consts.vh"

module slx_load_exec #(
  parameter T_DIV = 1
) (
  clk_sys,
  rst,
  start,
  start_pc,
  mem_rdata,
  dbg_sel,
  busy_ff,
  done_ff,
  illegal_ff,
  m1_ff,
  mem_rd_ff,
  mem_wr_ff,
  mem_addr_ff,
  mem_wdata_ff,
  pc_ff,
  mcycles_ff,
  tstates_ff,
  flags_we_ff,
  dbg_data_ff
);
  input wire clk_sys;
  input wire rst;
  input wire start;
  input wire [15:0] start_pc;
  input wire [7:0] mem_rdata;
  input wire [2:0] dbg_sel;
  output reg busy_ff;
  output reg done_ff;
  output reg illegal_ff;
  output reg m1_ff;
  output reg mem_rd_ff;
  output reg mem_wr_ff;
  output reg [15:0] mem_addr_ff;
  output reg [7:0] mem_wdata_ff;
  output reg [15:0] pc_ff;
  output reg [2:0] mcycles_ff;
  output reg [4:0] tstates_ff;
  output reg flags_we_ff;
  output reg [15:0] dbg_data_ff;

  // Sequencer states, one per machine cycle kind
  localparam S_IDLE = 3'h0;
  localparam S_OP1 = 3'h1;
  localparam S_OP2 = 3'h2;
  localparam S_ADR_LO = 3'h3;
  localparam S_ADR_HI = 3'h4;
  localparam S_DAT_LO = 3'h5;
  localparam S_DAT_HI = 3'h6;

  // Instruction kinds
  localparam K_IMM = 2'h0;
  localparam K_LOAD = 2'h1;
  localparam K_STORE = 2'h2;

  reg [2:0] state_ff;
  reg [1:0] kind_ff;
  reg [2:0] slot_ff;
  reg [7:0] prefix_ff;
  reg [15:0] word_ff;
  reg [7:0] data_lo_ff;
  reg kick_ff;
  reg [2:0] kick_len_ff;

  // Timer busy level left unread: the sequencer state already says it
  wire mc_tick;
  wire mc_last;
  wire [15:0] rf_rdata;
  wire [15:0] rf_dbg;
  reg rf_we;
  reg [15:0] rf_wdata;

  // Pair field to register slot mapping, used by both decode stages
  function [2:0] pair_slot;
    input [1:0] pair_select_field;
    begin
      case (pair_select_field)
        2'h0: pair_slot = `SLX_SLOT_FIRST;
        2'h1: pair_slot = `SLX_SLOT_SECOND;
        2'h2: pair_slot = `SLX_SLOT_THIRD;
        default: pair_slot = `SLX_SLOT_STACK;
      endcase
    end
  endfunction

  // Index register slot chosen by the prefix byte
  function [2:0] index_slot;
    input [7:0] pfx;
    begin
      index_slot = (pfx == `SLX_PFX_YIDX) ? `SLX_SLOT_YIDX : `SLX_SLOT_XIDX;
    end
  endfunction

  slx_mcycle #(
    .T_DIV(T_DIV)
  ) u_mcycle (
    .clk_sys(clk_sys),
    .rst(rst),
    .kick(kick_ff),
    .kick_len(kick_len_ff),
    .busy(),
    .tick(mc_tick),
    .last(mc_last)
  );

  slx_regfile #(
    .DEPTH(8),
    .AW(3)
  ) u_regfile (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(rf_we),
    .wr_addr(slot_ff),
    .wr_data(rf_wdata),
    .rd_addr(slot_ff),
    .rd_data_ff(rf_rdata),
    .dbg_addr(dbg_sel),
    .dbg_data_ff(rf_dbg)
  );

  // Register write at the end of the final cycle; high byte is live bus data
  always @* begin
    rf_we = 1'b0;
    rf_wdata = {mem_rdata, word_ff[7:0]};
    if (mc_last && state_ff == S_ADR_HI && kind_ff == K_IMM) begin
      rf_we = 1'b1;
    end
    if (mc_last && state_ff == S_DAT_HI && kind_ff == K_LOAD) begin
      rf_we = 1'b1;
      rf_wdata = {mem_rdata, data_lo_ff};
    end
  end

  // Main sequencer; leaves idle on any edge with start, otherwise acts only on the closing edge of each machine cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      kind_ff <= K_IMM;
      slot_ff <= `SLX_SLOT_FIRST;
      prefix_ff <= `SLX_RST_BYTE;
      word_ff <= `SLX_RST_WORD;
      data_lo_ff <= `SLX_RST_BYTE;
      kick_ff <= 1'b0;
      kick_len_ff <= `SLX_TS_FETCH;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
      m1_ff <= 1'b0;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_addr_ff <= `SLX_RST_WORD;
      mem_wdata_ff <= `SLX_RST_BYTE;
      pc_ff <= `SLX_RST_WORD;
      mcycles_ff <= 3'h0;
      tstates_ff <= 5'h00;
      flags_we_ff <= 1'b0;
      dbg_data_ff <= `SLX_RST_WORD;
    end else begin
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
      kick_ff <= 1'b0;
      flags_we_ff <= 1'b0; // Flag bank never written by this group
      dbg_data_ff <= rf_dbg;
      // Clock-state and machine-cycle tallies for the running instruction
      if (mc_tick) begin
        tstates_ff <= tstates_ff + 5'h01;
      end
      if (kick_ff) begin
        mcycles_ff <= mcycles_ff + 3'h1;
      end
      case (state_ff)
        S_IDLE: begin
          if (start) begin
            state_ff <= S_OP1;
            busy_ff <= 1'b1;
            pc_ff <= start_pc;
            mem_addr_ff <= start_pc;
            mem_rd_ff <= 1'b1;
            m1_ff <= 1'b1;
            kick_ff <= 1'b1;
            kick_len_ff <= `SLX_TS_FETCH;
            prefix_ff <= `SLX_RST_BYTE;
            mcycles_ff <= 3'h0;
            tstates_ff <= 5'h00;
          end
        end
        S_OP1: begin
          if (mc_last) begin
            pc_ff <= pc_ff + 16'h0001;
            mem_addr_ff <= pc_ff + 16'h0001;
            kick_ff <= 1'b1;
            kick_len_ff <= `SLX_TS_MEM;
            state_ff <= S_ADR_LO;
            m1_ff <= 1'b0;
            if (mem_rdata == `SLX_PFX_XIDX || mem_rdata == `SLX_PFX_YIDX ||
                mem_rdata == `SLX_PFX_EXT) begin
              // Prefix: second opcode fetch is also four states
              prefix_ff <= mem_rdata;
              state_ff <= S_OP2;
              m1_ff <= 1'b1;
              kick_len_ff <= `SLX_TS_FETCH;
            end else if (mem_rdata[7:6] == `SLX_IMM_TOP &&
                         mem_rdata[3:0] == `SLX_IMM_LOW) begin
              kind_ff <= K_IMM;
              slot_ff <= pair_slot(mem_rdata[5:4]);
            end else if (mem_rdata == `SLX_OP_LOAD_THIRD) begin
              kind_ff <= K_LOAD;
              slot_ff <= `SLX_SLOT_THIRD;
            end else if (mem_rdata == `SLX_OP_STORE_THIRD) begin
              kind_ff <= K_STORE;
              slot_ff <= `SLX_SLOT_THIRD;
            end else begin
              // Outside this group: hand back at once, no register written; pc_ff still steps past the opcode
              state_ff <= S_IDLE;
              kick_ff <= 1'b0;
              mem_rd_ff <= 1'b0;
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
              illegal_ff <= 1'b1;
            end
          end
        end
        S_OP2: begin
          if (mc_last) begin
            pc_ff <= pc_ff + 16'h0001;
            mem_addr_ff <= pc_ff + 16'h0001;
            m1_ff <= 1'b0;
            kick_ff <= 1'b1;
            kick_len_ff <= `SLX_TS_MEM;
            state_ff <= S_ADR_LO;
            if (prefix_ff != `SLX_PFX_EXT && mem_rdata == `SLX_OP_IDX_IMM) begin
              kind_ff <= K_IMM;
              slot_ff <= index_slot(prefix_ff);
            end else if (prefix_ff != `SLX_PFX_EXT &&
                         mem_rdata == `SLX_OP_LOAD_THIRD) begin
              kind_ff <= K_LOAD;
              slot_ff <= index_slot(prefix_ff);
            end else if (prefix_ff == `SLX_PFX_XIDX &&
                         mem_rdata == `SLX_OP_STORE_THIRD) begin
              kind_ff <= K_STORE;
              slot_ff <= `SLX_SLOT_XIDX;
            end else if (prefix_ff == `SLX_PFX_EXT &&
                         mem_rdata[7:6] == `SLX_EXT_TOP &&
                         mem_rdata[3:0] == `SLX_EXT_LOAD_LOW) begin
              kind_ff <= K_LOAD;
              slot_ff <= pair_slot(mem_rdata[5:4]);
            end else if (prefix_ff == `SLX_PFX_EXT &&
                         mem_rdata[7:6] == `SLX_EXT_TOP &&
                         mem_rdata[3:0] == `SLX_EXT_STORE_LOW) begin
              kind_ff <= K_STORE;
              slot_ff <= pair_slot(mem_rdata[5:4]);
            end else begin
              state_ff <= S_IDLE;
              kick_ff <= 1'b0;
              mem_rd_ff <= 1'b0;
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
              illegal_ff <= 1'b1;
            end
          end
        end
        S_ADR_LO: begin
          // First operand byte is always the low half of the word
          if (mc_last) begin
            word_ff[7:0] <= mem_rdata;
            pc_ff <= pc_ff + 16'h0001;
            mem_addr_ff <= pc_ff + 16'h0001;
            kick_ff <= 1'b1;
            state_ff <= S_ADR_HI;
          end
        end
        S_ADR_HI: begin
          if (mc_last) begin
            word_ff[15:8] <= mem_rdata;
            pc_ff <= pc_ff + 16'h0001;
            if (kind_ff == K_IMM) begin
              // Immediate forms finish here; the register write is above
              state_ff <= S_IDLE;
              mem_rd_ff <= 1'b0;
              busy_ff <= 1'b0;
              done_ff <= 1'b1;
            end else begin
              // Data cycles start only once the whole address is known
              state_ff <= S_DAT_LO;
              mem_addr_ff <= {mem_rdata, word_ff[7:0]};
              mem_rd_ff <= (kind_ff == K_LOAD);
              mem_wr_ff <= (kind_ff == K_STORE);
              mem_wdata_ff <= rf_rdata[7:0];
              kick_ff <= 1'b1;
            end
          end
        end
        S_DAT_LO: begin
          // Low byte at the address, high byte at the next one up
          if (mc_last) begin
            data_lo_ff <= mem_rdata;
            mem_addr_ff <= word_ff + 16'h0001;
            mem_wdata_ff <= rf_rdata[15:8];
            kick_ff <= 1'b1;
            state_ff <= S_DAT_HI;
          end
        end
        S_DAT_HI: begin
          if (mc_last) begin
            state_ff <= S_IDLE;
            mem_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= S_IDLE;
          busy_ff <= 1'b0;
          mem_rd_ff <= 1'b0;
          mem_wr_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** rtl/slx_mcycle.v ***
// Machine cycle timer: counts clock states of one bus cycle.
// Assumes a one-cycle kick; a clock state lasts T_DIV clk_sys cycles.
`timescale 1ns/100ps
`include "slx_consts.vh"

module slx_mcycle #(
  parameter T_DIV = 1
) (
  clk_sys,
  rst,
  kick,
  kick_len,
  busy,
  tick,
  last
);
  input wire clk_sys;
  input wire rst;
  input wire kick;
  input wire [2:0] kick_len;
  output wire busy;
  output wire tick;
  output wire last;

  reg busy_ff;
  reg [2:0] len_ff;
  reg [2:0] tcnt_ff;
  reg [7:0] div_ff;

  // Clock-state enable from the divider, restarted by each kick
  assign tick = busy_ff && (div_ff == T_DIV[7:0] - 8'h01);
  assign last = tick && (tcnt_ff == len_ff - 3'h1);
  assign busy = busy_ff;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      len_ff <= `SLX_TS_MEM;
      tcnt_ff <= 3'h0;
      div_ff <= 8'h00;
    end else if (kick) begin
      busy_ff <= 1'b1;
      len_ff <= kick_len;
      tcnt_ff <= 3'h0;
      div_ff <= 8'h00;
    end else if (busy_ff) begin
      if (tick) begin
        div_ff <= 8'h00;
        tcnt_ff <= tcnt_ff + 3'h1;
        if (last) begin
          busy_ff <= 1'b0;
        end
      end else begin
        div_ff <= div_ff + 8'h01;
      end
    end
  end

endmodule

// *** rtl/slx_regfile.v ***
// Word register file holding the pairs, stack pointer and index registers.
// Assumes one synchronous write port; both read ports give registered data.
`timescale 1ns/100ps
`include "slx_consts.vh"

module slx_regfile #(
  parameter DEPTH = 8,
  parameter AW = 3
) (
  clk_sys,
  rst,
  wr_en,
  wr_addr,
  wr_data,
  rd_addr,
  rd_data_ff,
  dbg_addr,
  dbg_data_ff
);
  input wire clk_sys;
  input wire rst;
  input wire wr_en;
  input wire [AW-1:0] wr_addr;
  input wire [15:0] wr_data;
  input wire [AW-1:0] rd_addr;
  output reg [15:0] rd_data_ff;
  input wire [AW-1:0] dbg_addr;
  output reg [15:0] dbg_data_ff;

  reg [15:0] mem_ff [0:DEPTH-1];
  integer i;

  // Storage and registered reads; reads see the old word on a same-cycle write
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= `SLX_RST_WORD;
      end
      rd_data_ff <= `SLX_RST_WORD;
      dbg_data_ff <= `SLX_RST_WORD;
    end else begin
      if (wr_en) begin
        mem_ff[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem_ff[rd_addr];
      dbg_data_ff <= mem_ff[dbg_addr];
    end
  end

endmodule

// *** sim/slx_load_exec_properties.sv ***
// Checker for the sixteen-bit load execution block.
// Assumes a bind onto slx_load_exec; sees only its ports.
`timescale 1ns/100ps
module slx_load_exec_chk #(
  parameter T_DIV = 1
) (
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire busy_ff,
  input wire done_ff,
  input wire illegal_ff,
  input wire m1_ff,
  input wire mem_rd_ff,
  input wire mem_wr_ff,
  input wire [15:0] mem_addr_ff,
  input wire [7:0] mem_wdata_ff,
  input wire [2:0] mcycles_ff,
  input wire [4:0] tstates_ff,
  input wire flags_we_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_flags_kept: assert property (!flags_we_ff)
    else $error("flag bank written");
  // Counts settle with done; a start right after done clears them next edge
  a_cycle_counts: assert property (done_ff && !illegal_ff |->
    (mcycles_ff == 3'h3 && tstates_ff == 5'h0A) ||
    (mcycles_ff == 3'h4 && tstates_ff == 5'h0E) ||
    (mcycles_ff == 3'h5 && tstates_ff == 5'h10) ||
    (mcycles_ff == 3'h6 && tstates_ff == 5'h14))
    else $error("bad cycle counts");
  a_done_ends_busy: assert property (done_ff |-> !busy_ff && $past(busy_ff))
    else $error("done not at end of busy");
  a_illegal_pulse: assert property (illegal_ff |-> done_ff ##1 !illegal_ff)
    else $error("illegal not a done pulse");
  a_start_taken: assert property (start && !busy_ff |=> busy_ff)
    else $error("start not taken");
  a_fetch_first: assert property ($rose(busy_ff) |-> m1_ff && mem_rd_ff)
    else $error("no opcode fetch first");
  // An unknown first opcode ends after one fetch, so five cycles is the floor
  a_busy_min: assert property ($rose(busy_ff) |-> busy_ff [*5])
    else $error("instruction too short");
  a_rd_wr_apart: assert property (!(mem_rd_ff && mem_wr_ff))
    else $error("read and write together");
  a_wr_whole: assert property ($rose(mem_wr_ff) |-> mem_wr_ff [*6])
    else $error("write cycles cut short");
  a_wr_ascend: assert property (mem_wr_ff && $past(mem_wr_ff) &&
    mem_addr_ff != $past(mem_addr_ff) |-> mem_addr_ff - $past(mem_addr_ff) == 16'h0001)
    else $error("write addresses not ascending");
  a_wr_data_steady: assert property (mem_wr_ff && $past(mem_wr_ff) &&
    $stable(mem_addr_ff) |-> $stable(mem_wdata_ff))
    else $error("write data moved");
endmodule

bind slx_load_exec slx_load_exec_chk #(.T_DIV(T_DIV)) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .start(start),
  .busy_ff(busy_ff),
  .done_ff(done_ff),
  .illegal_ff(illegal_ff),
  .m1_ff(m1_ff),
  .mem_rd_ff(mem_rd_ff),
  .mem_wr_ff(mem_wr_ff),
  .mem_addr_ff(mem_addr_ff),
  .mem_wdata_ff(mem_wdata_ff),
  .mcycles_ff(mcycles_ff),
  .tstates_ff(tstates_ff),
  .flags_we_ff(flags_we_ff)
);

// *** sim/slx_mem_model.sv ***
// Byte-wide zero-wait memory on the processor bus.
// Assumes registered bus controls on the same clock.
`timescale 1ns/100ps
module slx_mem_model (
  input wire clk_sys,
  input wire rd,
  input wire wr,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  reg [7:0] mem [0:65535];
  reg [7:0] last_ff = 8'h5A;

  // Released bus shows the inverse of the last byte, never a stale copy
  assign rdata = rd ? mem[addr] : ~last_ff;

  // Write stands all cycle, so the last edge wins
  always @(posedge clk_sys) begin
    if (wr) begin
      mem[addr] <= wdata;
    end
    if (rd) begin
      last_ff <= mem[addr];
    end
  end

  task poke(input [15:0] a, input [7:0] d);
    mem[a] = d;
  endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the sixteen-bit load execution block.
// Assumes T_DIV of 1 and the zero-wait memory model.
`timescale 1ns/100ps
module tb_top;
  reg clk_sys;
  reg rst;
  reg start;
  reg [15:0] start_pc;
  reg [2:0] dbg_sel;
  wire [7:0] mem_rdata;
  wire busy_ff, done_ff, illegal_ff, m1_ff, mem_rd_ff, mem_wr_ff, flags_we_ff;
  wire [15:0] mem_addr_ff;
  wire [7:0] mem_wdata_ff;
  wire [15:0] pc_ff;
  wire [2:0] mcycles_ff;
  wire [4:0] tstates_ff;
  wire [15:0] dbg_data_ff;
  integer n_mismatch;
  integer num_checks;
  reg [15:0] pc_run;

  slx_load_exec #(.T_DIV(1)) dut (.clk_sys(clk_sys), .rst(rst), .start(start),
    .start_pc(start_pc), .mem_rdata(mem_rdata), .dbg_sel(dbg_sel), .busy_ff(busy_ff),
    .done_ff(done_ff), .illegal_ff(illegal_ff), .m1_ff(m1_ff), .mem_rd_ff(mem_rd_ff),
    .mem_wr_ff(mem_wr_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff),
    .pc_ff(pc_ff), .mcycles_ff(mcycles_ff), .tstates_ff(tstates_ff),
    .flags_we_ff(flags_we_ff), .dbg_data_ff(dbg_data_ff));
  slx_mem_model u_mem (.clk_sys(clk_sys), .rd(mem_rd_ff), .wr(mem_wr_ff),
    .addr(mem_addr_ff), .wdata(mem_wdata_ff), .rdata(mem_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task chk(input [15:0] seen, input [15:0] exp, input string what);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t %0s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Program n bytes, run once; a second start mid-run must be ignored
  task exec(input [31:0] code, input integer n, input [2:0] em, input [4:0] et, input ill);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      u_mem.poke(pc_run + i[15:0], code[31-8*i -: 8]);
    end
    start_pc = pc_run;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    start_pc = 16'hFFFF;
    repeat (3) @(negedge clk_sys);
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    for (i = 0; i < 40 && done_ff !== 1'b1; i = i + 1) begin
      @(negedge clk_sys);
    end
    if (done_ff !== 1'b1) begin
      chk(1'b0, 1'b1, "done timeout");
      conclude;
    end else begin
      chk(illegal_ff, ill, "illegal flag");
      chk(pc_ff, pc_run + n[15:0], "pc");
      if (!ill) begin
        chk(mcycles_ff, em, "mcycles");
        chk(tstates_ff, et, "tstates");
      end
      @(negedge clk_sys);
      pc_run = pc_run + 16'h0010;
    end
  endtask

  // Debug read port has two clocks of latency
  task chk_slot(input [2:0] s, input [15:0] exp);
    dbg_sel = s;
    repeat (3) @(negedge clk_sys);
    chk(dbg_data_ff, exp, "slot");
  endtask

  task t_imm;
    integer d;
    for (d = 0; d < 4; d = d + 1) begin
      exec({2'h0, d[1:0], 4'h1, 8'h10 + d[7:0], 8'hC0 + d[7:0], 8'h00}, 3, 3'h3, 5'h0A, 1'b0);
      chk_slot(d[2:0], {8'hC0 + d[7:0], 8'h10 + d[7:0]});
    end
    exec({8'hDD, 8'h21, 8'h34, 8'h12}, 4, 3'h4, 5'h0E, 1'b0);
    chk_slot(3'h4, 16'h1234);
    exec({8'hFD, 8'h21, 8'h78, 8'h56}, 4, 3'h4, 5'h0E, 1'b0);
    chk_slot(3'h5, 16'h5678);
  endtask

  // Word straddles a page so the high byte needs a carry into addr+1
  task t_load;
    integer d;
    u_mem.poke(16'h80FF, 8'h37);
    u_mem.poke(16'h8100, 8'hA1);
    exec({8'h2A, 8'hFF, 8'h80, 8'h00}, 3, 3'h5, 5'h10, 1'b0);
    chk_slot(3'h2, 16'hA137);
    for (d = 0; d < 4; d = d + 1) begin
      u_mem.poke(16'h8100, 8'hA0 + d[7:0]);
      exec({8'hED, 2'h1, d[1:0], 4'hB, 8'hFF, 8'h80}, 4, 3'h6, 5'h14, 1'b0);
      chk_slot(d[2:0], {8'hA0 + d[7:0], 8'h37});
    end
    u_mem.poke(16'h8100, 8'hB4);
    exec({8'hDD, 8'h2A, 8'hFF, 8'h80}, 4, 3'h6, 5'h14, 1'b0);
    chk_slot(3'h4, 16'hB437);
    u_mem.poke(16'h8100, 8'hB5);
    exec({8'hFD, 8'h2A, 8'hFF, 8'h80}, 4, 3'h6, 5'h14, 1'b0);
    chk_slot(3'h5, 16'hB537);
  endtask

  task t_store;
    integer d;
    exec({8'h22, 8'hFF, 8'h90, 8'h00}, 3, 3'h5, 5'h10, 1'b0);
    chk(u_mem.mem[16'h90FF], 8'h37, "store lo");
    chk(u_mem.mem[16'h9100], 8'hA2, "store hi");
    for (d = 0; d < 4; d = d + 1) begin
      exec({8'hED, 2'h1, d[1:0], 4'h3, 8'h10 * d[7:0], 8'h92}, 4, 3'h6, 5'h14, 1'b0);
      chk(u_mem.mem[{8'h92, 8'h10 * d[7:0]}], 8'h37, "ext lo");
      chk(u_mem.mem[{8'h92, 8'h10 * d[7:0] + 8'h01}], 8'hA0 + d[7:0], "ext hi");
    end
    exec({8'hDD, 8'h22, 8'h00, 8'h93}, 4, 3'h6, 5'h14, 1'b0);
    chk(u_mem.mem[16'h9300], 8'h37, "x lo");
    chk(u_mem.mem[16'h9301], 8'hB4, "x hi");
  endtask

  // Store of index y and an unknown opcode are refused, nothing written
  task t_ill;
    exec({8'h00, 24'h000000}, 1, 3'h0, 5'h00, 1'b1);
    u_mem.poke(16'h9400, 8'h66);
    exec({8'hFD, 8'h22, 8'h00, 8'h94}, 2, 3'h0, 5'h00, 1'b1);
    chk(u_mem.mem[16'h9400], 8'h66, "no write");
    chk_slot(3'h5, 16'hB537);
  endtask

  initial begin
    rst = 1'b1;
    start = 1'b0;
    start_pc = 16'h0000;
    dbg_sel = 3'h0;
    n_mismatch = 0;
    num_checks = 0;
    pc_run = 16'h0100;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    chk(busy_ff, 1'b0, "idle after reset");
    t_imm;
    t_load;
    t_store;
    t_ill;
    conclude;
  end
endmodule
